/* bench/tb_pdr_regs.sv */
// Self-checking bench for the loop divider and power-down register bank.
module tb_pdr_regs import pdr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [9:0]  adr = '0;
   logic [3:0]  sel = '0;
   logic [31:0] wdat = '0;
   logic [31:0] rdat;
   logic        ack;
   logic [7:0]  m_code;
   logic [8:0]  m_value;
   logic        m_valid;
   logic [3:0]  n_code;
   logic [4:0]  n_value;
   logic [1:0]  bias_t;
   logic [5:0]  coarse;
   logic        bias, temp, loop, clkrx, sref, ch_a, ch_b, ch_c, ch_d;
   logic [15:0] exp_loop, exp_pwr;
   logic [31:0] rd;
   logic [9:0]  ra;
   logic [7:0]  m_list [8] = '{8'h00, 8'h03, 8'h04, 8'h7f,
                               8'h80, 8'h83, 8'h84, 8'hff};
   int          fails = 0;
   int          compares = 0;

   pdr_regs dut (.CLK_SYS(clk), .RESET(reset), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .LOOP_M_CODE(m_code), .LOOP_M_VALUE(m_value),
      .LOOP_M_VALID(m_valid), .LOOP_N_CODE(n_code),
      .LOOP_N_VALUE(n_value), .OSC_BIAS_TUNE(bias_t),
      .OSC_COARSE_TUNE(coarse), .BIAS_AMP_POWER_DOWN(bias),
      .TEMP_SENSOR_POWER_DOWN(temp), .LOOP_POWER_DOWN(loop),
      .CLOCK_RECEIVER_POWER_DOWN(clkrx),
      .SYNC_REF_CLOCK_INPUT_POWER_DOWN(sref),
      .CHANNEL_A_POWER_DOWN(ch_a), .CHANNEL_B_POWER_DOWN(ch_b),
      .CHANNEL_C_POWER_DOWN(ch_c), .CHANNEL_D_POWER_DOWN(ch_d));

   always #5 clk = ~clk;

   function automatic logic [8:0] m_exp(input logic [7:0] c);
      return c[7] ? {1'b0, c[6:0], 1'b0} : {2'b00, c[6:0]};
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Holds the request until ack is seen high at a rising edge.
   task automatic wb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      wb(1'b1, a, d, s);
      if (a == ADDR_LOOP_DIVIDER) exp_loop = merge(exp_loop, d, s) & 16'hfffc;
      if (a == ADDR_POWER_DOWN) exp_pwr = merge(exp_pwr, d, s) & 16'hfcff;
   endtask

   task automatic check_outs;
      wb(1'b0, ADDR_LOOP_DIVIDER, 32'h0, 4'hf);
      check(rd, {16'h0000, exp_loop});
      wb(1'b0, ADDR_POWER_DOWN, 32'h0, 4'hf);
      check(rd, {16'h0000, exp_pwr});
      check(m_code, exp_loop[15:8]);
      check(m_value, m_exp(exp_loop[15:8]));
      check(m_valid, exp_loop[14:8] >= 7'h04);
      check(n_value, exp_loop[7:4] + 5'h01);
      check({n_code, bias_t}, exp_loop[7:2]);
      check({coarse, 2'b00, bias, temp, loop, clkrx, ch_a, ch_b, ch_c, ch_d},
            exp_pwr);
      check(sref, exp_pwr[4]);
   endtask

   task automatic do_reset(input int n);
      reset <= 1'b1;
      repeat (n) @(posedge clk);
      reset <= 1'b0;
      exp_loop = 16'h0440;
      exp_pwr = 16'h0020;
      @(posedge clk);
   endtask

   task automatic final_report;
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      void'($urandom(32'h2d2d7a2a));
      @(posedge clk);
      do_reset(4);
      check_outs();
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_LOOP_DIVIDER, {16'h0, m_list[i % 8], i[3:0], 4'h4},
            4'h3);
         check_outs();
      end
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_POWER_DOWN, 32'h1 << i, 4'h3);
         check_outs();
      end
      wr(ADDR_LOOP_DIVIDER, 32'h0000_12b7, 4'h1);
      check_outs();
      wr(ADDR_POWER_DOWN, 32'h0000_ab5a, 4'h2);
      check_outs();
      wb(1'b0, 10'h3fc, 32'h0, 4'hf);
      check(rd, 32'h0);
      repeat (24) begin
         case ($urandom_range(2))
            0: ra = ADDR_LOOP_DIVIDER;
            1: ra = ADDR_POWER_DOWN;
            default: ra = 10'h100 + 10'($urandom_range(255));
         endcase
         wr(ra, $urandom, 4'($urandom));
         check_outs();
      end
      wr(ADDR_POWER_DOWN, 32'hffff, 4'hf);
      check_outs();
      do_reset(2);
      check_outs();
      final_report();
   end

   initial begin
      #100000;
      fails++;
      final_report();
   end
endmodule

/* design/pdr_m_decode.sv */
// Decoder of the M and N divider codes into divide values.
module pdr_m_decode
   import pdr_pkg::*;
(
   input  wire logic [7:0] m_code,
   input  wire logic [3:0] n_code,
   output logic      [8:0] m_value,
   output logic            m_valid,
   output logic      [4:0] n_value
);
   wire logic [8:0] m_direct  = {2'b00, m_code[6:0]};
   wire logic [8:0] m_doubled = {1'b0, m_code[6:0], 1'b0};
   wire logic       low_ok    = m_code[6:0] >= M_MIN_DIRECT[6:0];

   assign m_value = m_code[7] ? m_doubled : m_direct;
   assign m_valid = low_ok;
   assign n_value = {1'b0, n_code} + 5'h01;
endmodule

/* design/pdr_pkg.sv */
// Offsets, field positions and reset values of the loop and sleep registers.
package pdr_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0]  IDX_LOOP_DIVIDER  = 8'h19;
   localparam logic [7:0]  IDX_POWER_DOWN    = 8'h1a;
   localparam logic [9:0]  ADDR_LOOP_DIVIDER = {IDX_LOOP_DIVIDER, 2'b00};
   localparam logic [9:0]  ADDR_POWER_DOWN   = {IDX_POWER_DOWN, 2'b00};
   localparam logic [15:0] RST_LOOP_DIVIDER  = 16'h0440;
   localparam logic [15:0] RST_POWER_DOWN    = 16'h0020;
   // Field positions.
   localparam int M_HI        = 15;
   localparam int M_LO        = 8;
   localparam int N_HI        = 7;
   localparam int N_LO        = 4;
   localparam int BIAS_HI     = 3;
   localparam int BIAS_LO     = 2;
   localparam int COARSE_HI   = 15;
   localparam int COARSE_LO   = 10;
   localparam int BIT_BIAS    = 7;
   localparam int BIT_TEMP    = 6;
   localparam int BIT_LOOP    = 5;
   localparam int BIT_CLKRX   = 4;
   localparam int BIT_CH_A    = 3;
   localparam int BIT_CH_B    = 2;
   localparam int BIT_CH_C    = 1;
   localparam int BIT_CH_D    = 0;
   // Writable masks: reserved bits stay at zero.
   localparam logic [15:0] MASK_LOOP_DIVIDER = 16'hfffc;
   localparam logic [15:0] MASK_POWER_DOWN   = 16'hfcff;
   // Smallest legal low seven M code bits in the direct and doubled ranges.
   localparam logic [7:0]  M_MIN_DIRECT  = 8'h04;
   localparam logic [7:0]  M_MIN_DOUBLE  = 8'h04;
endpackage

/* design/pdr_regs.sv */
// Loop divider and power-down register bank behind a Wishbone slave port.
// Function
// - With the M code top bit clear, M is the low seven bits, legal 4 to 127.
// - With the M code top bit set, M is twice the low seven bits, 8 to 254.
// - The four-bit N code in bits 7:4 decodes to N equal to code plus one.
// - The loop divider register resets to 0x0440.
// - Reserved bits of both registers reset to zero and stay there.
// - Bits 15:10 of the power-down register hold coarse tune, reset zero.
// - Bit 7 set holds the bias amplifier asleep; resets to 0.
// - Bit 6 set switches the temperature sensor off; resets to 0.
// - Bit 5 set keeps the loop asleep; resets to 1.
// - Bit 4 set sleeps the clock receiver and the sync reference receiver.
// - Bits 3 to 0 sleep channels A to D respectively; each resets to 0.
// - The power-down register resets to 0x0020.
module pdr_regs
   import pdr_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [9:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic      [7:0]  LOOP_M_CODE,
   output logic      [8:0]  LOOP_M_VALUE,
   output logic             LOOP_M_VALID,
   output logic      [3:0]  LOOP_N_CODE,
   output logic      [4:0]  LOOP_N_VALUE,
   output logic      [1:0]  OSC_BIAS_TUNE,
   output logic      [5:0]  OSC_COARSE_TUNE,
   output logic             BIAS_AMP_POWER_DOWN,
   output logic             TEMP_SENSOR_POWER_DOWN,
   output logic             LOOP_POWER_DOWN,
   output logic             CLOCK_RECEIVER_POWER_DOWN,
   output logic             SYNC_REF_CLOCK_INPUT_POWER_DOWN,
   output logic             CHANNEL_A_POWER_DOWN,
   output logic             CHANNEL_B_POWER_DOWN,
   output logic             CHANNEL_C_POWER_DOWN,
   output logic             CHANNEL_D_POWER_DOWN
);
   logic [15:0] loop_divider_config;
   logic [15:0] power_down_config;
   logic [31:0] read_data;
   logic        take;

   pdr_wb_slave u_slave (
      .clk   (CLK_SYS),
      .reset (RESET),
      .cyc   (WB_CYC_I),
      .stb   (WB_STB_I),
      .ack   (WB_ACK_O),
      .take  (take)
   );

   // Merge the two low byte lanes into a 16-bit register under a write mask.
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wdata,
                                         input logic [3:0]  sel,
                                         input logic [15:0] mask);
      logic [15:0] lane;
      lane = {sel[1] ? wdata[15:8] : old[15:8],
              sel[0] ? wdata[7:0]  : old[7:0]};
      return lane & mask;
   endfunction

   wire logic hit_loop  = WB_ADR_I == ADDR_LOOP_DIVIDER;
   wire logic hit_power = WB_ADR_I == ADDR_POWER_DOWN;
   // A write lands at the edge at which the master samples ack high, so the
   // controlled blocks never act on a transfer that is still pending.
   wire logic commit    = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I;
   wire logic wr_loop   = commit && hit_loop;
   wire logic wr_power  = commit && hit_power;

   wire logic [15:0] next_loop_divider_config =
      merge(loop_divider_config, WB_DAT_I, WB_SEL_I, MASK_LOOP_DIVIDER);
   wire logic [15:0] next_power_down_config =
      merge(power_down_config, WB_DAT_I, WB_SEL_I, MASK_POWER_DOWN);

   // Unmapped addresses still get an acknowledge and read as zero, so a
   // stray access never hangs the bus.
   wire logic [31:0] next_read_data =
      hit_loop  ? {16'h0000, loop_divider_config} :
      hit_power ? {16'h0000, power_down_config}   : 32'h0000_0000;

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         loop_divider_config <= RST_LOOP_DIVIDER;
         power_down_config   <= RST_POWER_DOWN;
      end else begin
         if (wr_loop) begin
            loop_divider_config <= next_loop_divider_config;
         end
         if (wr_power) begin
            power_down_config <= next_power_down_config;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         read_data <= 32'h0000_0000;
      end else if (take && !WB_WE_I) begin
         read_data <= next_read_data;
      end
   end

   assign WB_DAT_O = read_data;

   pdr_m_decode u_decode (
      .m_code  (loop_divider_config[M_HI:M_LO]),
      .n_code  (loop_divider_config[N_HI:N_LO]),
      .m_value (LOOP_M_VALUE),
      .m_valid (LOOP_M_VALID),
      .n_value (LOOP_N_VALUE)
   );

   assign LOOP_M_CODE     = loop_divider_config[M_HI:M_LO];
   assign LOOP_N_CODE     = loop_divider_config[N_HI:N_LO];
   assign OSC_BIAS_TUNE   = loop_divider_config[BIAS_HI:BIAS_LO];
   assign OSC_COARSE_TUNE = power_down_config[COARSE_HI:COARSE_LO];
   assign BIAS_AMP_POWER_DOWN       = power_down_config[BIT_BIAS];
   assign TEMP_SENSOR_POWER_DOWN    = power_down_config[BIT_TEMP];
   assign LOOP_POWER_DOWN           = power_down_config[BIT_LOOP];
   assign CLOCK_RECEIVER_POWER_DOWN = power_down_config[BIT_CLKRX];
   assign SYNC_REF_CLOCK_INPUT_POWER_DOWN =
      power_down_config[BIT_CLKRX];
   assign CHANNEL_A_POWER_DOWN = power_down_config[BIT_CH_A];
   assign CHANNEL_B_POWER_DOWN = power_down_config[BIT_CH_B];
   assign CHANNEL_C_POWER_DOWN = power_down_config[BIT_CH_C];
   assign CHANNEL_D_POWER_DOWN = power_down_config[BIT_CH_D];

   // Steps of a bus transfer: a request taken while ack is low, then the
   // acknowledge edge at which the transfer completes.
   sequence s_write_power;
      WB_CYC_I && WB_STB_I && WB_WE_I && hit_power && !WB_ACK_O;
   endsequence

   sequence s_write_loop;
      WB_CYC_I && WB_STB_I && WB_WE_I && hit_loop && !WB_ACK_O;
   endsequence

   sequence s_read_loop;
      WB_CYC_I && WB_STB_I && !WB_WE_I && hit_loop && !WB_ACK_O;
   endsequence

   sequence s_read_power;
      WB_CYC_I && WB_STB_I && !WB_WE_I && hit_power && !WB_ACK_O;
   endsequence

   sequence s_read_unmapped;
      WB_CYC_I && WB_STB_I && !WB_WE_I && !hit_loop && !hit_power
      && !WB_ACK_O;
   endsequence

   sequence s_request;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence

   sequence s_commit;
      WB_ACK_O && WB_CYC_I && WB_STB_I;
   endsequence

   a_loop_reset_value: assert property (@(posedge CLK_SYS)
      RESET |=> loop_divider_config == RST_LOOP_DIVIDER)
      else $error("loop divider register not at reset value");
   a_power_reset_value: assert property (@(posedge CLK_SYS)
      RESET |=> power_down_config == RST_POWER_DOWN && LOOP_POWER_DOWN)
      else $error("power-down register not at reset value");
   a_reserved_bits_zero: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      loop_divider_config[1:0] == 2'b00 && power_down_config[9:8] == 2'b00)
      else $error("reserved bit became set");
   a_m_value_decode: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      LOOP_M_CODE[7] |-> LOOP_M_VALUE == {1'b0, LOOP_M_CODE[6:0], 1'b0})
      else $error("doubled M value wrong");
   a_m_direct_decode: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      !LOOP_M_CODE[7] |-> LOOP_M_VALUE == {2'b00, LOOP_M_CODE[6:0]}
      && LOOP_M_VALID == (LOOP_M_CODE[6:0] > 7'h03))
      else $error("direct M value or validity wrong");
   a_n_value_decode: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      LOOP_N_VALUE == {1'b0, LOOP_N_CODE} + 5'h01)
      else $error("N value wrong");
   a_power_write_lands: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s_write_power and (WB_SEL_I == 4'hf)) |=> WB_ACK_O
      ##1 power_down_config
          == ($past(WB_DAT_I[15:0], 2) & MASK_POWER_DOWN))
      else $error("power-down write did not land");
   a_sync_rx_follows: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      SYNC_REF_CLOCK_INPUT_POWER_DOWN == CLOCK_RECEIVER_POWER_DOWN
      && CLOCK_RECEIVER_POWER_DOWN == power_down_config[4])
      else $error("receiver sleep outputs disagree");
   a_channel_sleep_map: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      {CHANNEL_A_POWER_DOWN, CHANNEL_B_POWER_DOWN, CHANNEL_C_POWER_DOWN,
       CHANNEL_D_POWER_DOWN} == power_down_config[3:0])
      else $error("channel sleep mapping wrong");
   a_ack_one_cycle: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");

   a_ack_after_take: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      s_request |=> WB_ACK_O)
      else $error("request not acknowledged in the next cycle");
   a_no_stray_ack: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
      else $error("acknowledge given without a request");
   a_bus_reset_value: assert property (@(posedge CLK_SYS)
      RESET |=> WB_DAT_O == 32'h0000_0000 && !WB_ACK_O)
      else $error("bus outputs not cleared by reset");

   // Read data is captured when the request is taken and must stand with
   // the acknowledge, since the master takes it at that edge only.
   a_read_loop_data: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      s_read_loop |=> WB_ACK_O
      && WB_DAT_O == {16'h0000, $past(loop_divider_config)})
      else $error("loop divider read returned a wrong value");
   a_read_power_data: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      s_read_power |=> WB_ACK_O
      && WB_DAT_O == {16'h0000, $past(power_down_config)})
      else $error("power-down read returned a wrong value");
   a_read_unmapped_zero: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      s_read_unmapped |=> WB_ACK_O && WB_DAT_O == 32'h0000_0000)
      else $error("unmapped read did not return zero");
   a_read_stands: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      WB_ACK_O |=> $stable(WB_DAT_O))
      else $error("read data changed right after the acknowledge");
   a_read_upper_zero: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      WB_DAT_O[31:16] == 16'h0000)
      else $error("upper half of read data not zero");

   a_loop_write_lands: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s_write_loop and (WB_SEL_I[1:0] == 2'b11)) |=> WB_ACK_O
      ##1 loop_divider_config
          == ($past(WB_DAT_I[15:0], 2) & MASK_LOOP_DIVIDER))
      else $error("loop divider write did not land");
   a_loop_lane_kept: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s_write_loop and (WB_SEL_I[1:0] == 2'b01)) ##1 s_commit
      |=> loop_divider_config[15:8] == $past(loop_divider_config[15:8], 2))
      else $error("unselected byte lane of loop divider changed");
   a_power_lane_kept: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      (s_write_power and (WB_SEL_I[1:0] == 2'b10)) ##1 s_commit
      |=> power_down_config[7:0] == $past(power_down_config[7:0], 2))
      else $error("unselected byte lane of power-down register changed");

   // Only an acknowledged write may move a register; a stray strobe or an
   // unmapped write must leave both untouched.
   a_loop_holds: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      !(WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && hit_loop)
      |=> $stable(loop_divider_config))
      else $error("loop divider changed without a write");
   a_power_holds: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      !(WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && hit_power)
      |=> $stable(power_down_config))
      else $error("power-down register changed without a write");

   a_sleep_bits_map: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      {BIAS_AMP_POWER_DOWN, TEMP_SENSOR_POWER_DOWN, LOOP_POWER_DOWN}
      == power_down_config[7:5])
      else $error("sleep outputs do not follow their register bits");
   a_coarse_tune_field: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      OSC_COARSE_TUNE == power_down_config[15:10])
      else $error("coarse tune output does not follow its field");
   a_bias_tune_field: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      OSC_BIAS_TUNE == loop_divider_config[3:2])
      else $error("bias tune output does not follow its field");
   a_doubled_m_valid: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      LOOP_M_CODE[7] |-> LOOP_M_VALID == (LOOP_M_CODE[6:0] > 7'h03))
      else $error("doubled M validity wrong");
   a_valid_m_range: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      LOOP_M_VALID |-> LOOP_M_VALUE >= 9'h004 && LOOP_M_VALUE <= 9'h0fe)
      else $error("M value flagged valid outside its range");
   a_n_value_range: assert property (@(posedge CLK_SYS)
      disable iff (RESET)
      LOOP_N_VALUE >= 5'h01 && LOOP_N_VALUE <= 5'h10)
      else $error("N value outside its range");
endmodule

/* design/pdr_wb_slave.sv */
// Classic Wishbone slave front end with one-cycle registered acknowledge.
module pdr_wb_slave
   import pdr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        cyc,
   input  wire logic        stb,
   output logic             ack,
   output logic             take
);
   wire logic req = cyc && stb && !ack;

   assign take = req;

   always_ff @(posedge clk) begin
      if (reset) begin
         ack <= 1'b0;
      end else begin
         ack <= req;
      end
   end
endmodule
